// File: sbo_if.sv
// Request/grant carrier between requesters and bus master logic
`timescale 1ns/1ps
interface sbo_if;
  logic iox_hostdata_return_request;
  logic coh_memreturn_request;
  logic coh_shared;
  logic coh_zerolen_return_strobe;
  logic [3:0] coh_zerolen_trans_id;
  logic iox_mem_read_request;
  logic [1:0] iox_mem_read_kind;
  logic iox_zerolen_hint;
  logic iox_mem_write_request;
  logic iox_io_read_request;
  logic iox_pio_return_request;
  logic iox_io_write_request;
  logic coh_sync_request;
  logic coh_purge_request;
  logic bin_broad_error_request;
  logic iox_stop_io;
  logic iox_cmd_reset;
  logic [9:0] grant;
  modport requester (
    output iox_hostdata_return_request, coh_memreturn_request, coh_shared,
    output coh_zerolen_return_strobe, coh_zerolen_trans_id,
    output iox_mem_read_request, iox_mem_read_kind, iox_zerolen_hint,
    output iox_mem_write_request, iox_io_read_request,
    output iox_pio_return_request, iox_io_write_request,
    output coh_sync_request, coh_purge_request, bin_broad_error_request,
    output iox_stop_io, iox_cmd_reset,
    input grant
  );
  modport master (
    input iox_hostdata_return_request, coh_memreturn_request, coh_shared,
    input coh_zerolen_return_strobe, coh_zerolen_trans_id,
    input iox_mem_read_request, iox_mem_read_kind, iox_zerolen_hint,
    input iox_mem_write_request, iox_io_read_request,
    input iox_pio_return_request, iox_io_write_request,
    input coh_sync_request, coh_purge_request, bin_broad_error_request,
    input iox_stop_io, iox_cmd_reset,
    output grant
  );
endinterface

// File: sbo_master.sv
// Bus master end: grants output requests and sequences bus states
`timescale 1ns/1ps
module sbo_master
  import sbo_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  sbo_if.master bus,
  output logic [7:0] bus_ttype,
  output logic bus_valid,
  output logic bus_zerolen_hint,
  output logic [3:0] zerolen_trans_id,
  output logic zerolen_return,
  output logic cmd_reset_seen
);
  // Bus occupancy, I/O spacing and this state's requests and grants
  sbo_state_e state_q;
  logic [2:0] left_q;
  logic [1:0] io_gap_q;
  logic [9:0] req;
  logic [9:0] gnt;
  logic io_ok;
  logic io_start;

  // Length of a transaction given its requester index; every index is
  // listed so that a new length needs only a package change
  function automatic logic [2:0] len_of(input int idx);
    case (idx)
      SBO_R_HOSTDATA: len_of = SBO_LEN_HOSTDATA;
      SBO_R_MEMRET: len_of = SBO_LEN_MEMRET;
      SBO_R_PIORET: len_of = SBO_LEN_PIORET;
      SBO_R_BERR: len_of = SBO_LEN_BERR;
      SBO_R_SYNC: len_of = SBO_LEN_SYNC;
      SBO_R_PURGE: len_of = SBO_LEN_PURGE;
      SBO_R_MEMRD: len_of = SBO_LEN_MEMRD;
      SBO_R_MEMWR: len_of = SBO_LEN_MEMWR;
      SBO_R_IORD: len_of = SBO_LEN_IORD;
      SBO_R_IOWR: len_of = SBO_LEN_IOWR;
      default: len_of = SBO_LEN_SYNC;
    endcase
  endfunction

  // True for the two requesters that count as I/O transactions;
  // both are held back by stop-I/O and by the spacing rule
  function automatic logic is_io(input int idx);
    is_io = (idx == SBO_R_IORD) || (idx == SBO_R_IOWR);
  endfunction

  // Gather request lines in priority order
  // Requests are levels that come straight from the requester's flops
  always_comb begin
    req = '0;
    req[SBO_R_HOSTDATA] = bus.iox_hostdata_return_request;
    req[SBO_R_MEMRET] = bus.coh_memreturn_request;
    req[SBO_R_PIORET] = bus.iox_pio_return_request;
    req[SBO_R_BERR] = bus.bin_broad_error_request;
    req[SBO_R_SYNC] = bus.coh_sync_request;
    req[SBO_R_PURGE] = bus.coh_purge_request;
    req[SBO_R_MEMRD] = bus.iox_mem_read_request;
    req[SBO_R_MEMWR] = bus.iox_mem_write_request;
    req[SBO_R_IORD] = bus.iox_io_read_request;
    req[SBO_R_IOWR] = bus.iox_io_write_request;
  end

  // I/O issue gated by stop-I/O and the two-state spacing; a held
  // request simply waits, so nothing is lost while I/O is stopped
  assign io_ok = !bus.iox_stop_io && (io_gap_q == 2'h0);

  // Fixed priority, one grant only while idle
  // Grant is combinational: a request made by logic would form a loop
  always_comb begin
    gnt = '0;
    if (state_q == SBO_IDLE) begin
      for (int i = 0; i < SBO_NREQ; i++) begin
        if (req[i] && gnt == '0 && (!is_io(i) || io_ok)) begin
          gnt[i] = 1'b1;
        end
      end
    end
  end
  assign bus.grant = gnt;
  // Start of an I/O transaction opens the spacing window
  assign io_start = gnt[SBO_R_IORD] || gnt[SBO_R_IOWR];

  // Occupancy counter: transaction holds the bus for its length
  // Single-state transactions never leave idle, so short ones can
  // follow each other with no dead state between them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SBO_IDLE;
      left_q <= 3'h0;
    end else begin
      case (state_q)
        SBO_IDLE: begin
          for (int i = 0; i < SBO_NREQ; i++) begin
            if (gnt[i] && len_of(i) > 3'h1) begin
              state_q <= SBO_BUSY;
              left_q <= len_of(i) - 3'h1;
            end
          end
        end
        SBO_BUSY: begin
          left_q <= left_q - 3'h1;
          if (left_q == 3'h1) begin
            state_q <= SBO_IDLE;
          end
        end
        default: state_q <= SBO_IDLE;
      endcase
    end
  end

  // Counts down the states left after an I/O start; a counter keeps the spacing
  // a package constant rather than a fixed one-state flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_gap_q <= 2'h0;
    end else if (io_start) begin
      io_gap_q <= SBO_IO_SPACING - 2'h1;
    end else if (io_gap_q != 2'h0) begin
      io_gap_q <= io_gap_q - 2'h1;
    end
  end

  // Transaction type is driven in the start state only
  // The chain cannot clash: at most one grant bit is ever set, so
  // the order of the lines below carries no meaning
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_ttype <= SBO_T_NONE;
      bus_valid <= 1'b0;
      bus_zerolen_hint <= 1'b0;
    end else begin
      bus_valid <= |gnt;
      bus_zerolen_hint <= gnt[SBO_R_MEMRD] && bus.iox_zerolen_hint;
      bus_ttype <= SBO_T_NONE;
      if (gnt[SBO_R_HOSTDATA]) begin
        bus_ttype <= SBO_T_HOSTCTL;
      end
      if (gnt[SBO_R_MEMRET]) begin
        // Shared flag turns a plain return into a shared one
        bus_ttype <= bus.coh_shared ? SBO_T_SHARRTN : SBO_T_HOSTCTL;
      end
      if (gnt[SBO_R_PIORET]) begin
        bus_ttype <= SBO_T_PIORTN;
      end
      if (gnt[SBO_R_BERR]) begin
        bus_ttype <= SBO_T_BERR;
      end
      if (gnt[SBO_R_SYNC]) begin
        bus_ttype <= SBO_T_SYNC;
      end
      if (gnt[SBO_R_PURGE]) begin
        bus_ttype <= SBO_T_PURGE;
      end
      if (gnt[SBO_R_MEMRD]) begin
        case (bus.iox_mem_read_kind)
          SBO_RD_CURRENT: bus_ttype <= SBO_T_RDCUR;
          SBO_RD_PRIV: bus_ttype <= SBO_T_RDPRIV;
          default: bus_ttype <= SBO_T_RDSOP;
        endcase
      end
      if (gnt[SBO_R_MEMWR]) begin
        bus_ttype <= SBO_T_WRBACK;
      end
      if (gnt[SBO_R_IORD]) begin
        bus_ttype <= SBO_T_RDSHORT;
      end
      if (gnt[SBO_R_IOWR]) begin
        bus_ttype <= SBO_T_WRSHORT;
      end
    end
  end

  // Zero-length return passes through without arbitration
  // It never takes the bus, so it may come in any state, even busy ones;
  // registered so that every output of this end but the grant comes from a flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zerolen_return <= 1'b0;
      zerolen_trans_id <= 4'h0;
      cmd_reset_seen <= 1'b0;
    end else begin
      zerolen_return <= bus.coh_zerolen_return_strobe;
      zerolen_trans_id <= bus.coh_zerolen_trans_id;
      cmd_reset_seen <= bus.iox_cmd_reset;
    end
  end
endmodule

// File: sbo_pkg.sv
// Shared constants and types for the system bus output request/grant link
package sbo_pkg;
  // Requester indices, also grant priority order (lowest index first)
  localparam int SBO_NREQ = 10;
  localparam int SBO_R_HOSTDATA = 0;
  localparam int SBO_R_MEMRET = 1;
  localparam int SBO_R_PIORET = 2;
  localparam int SBO_R_BERR = 3;
  localparam int SBO_R_SYNC = 4;
  localparam int SBO_R_PURGE = 5;
  localparam int SBO_R_MEMRD = 6;
  localparam int SBO_R_MEMWR = 7;
  localparam int SBO_R_IORD = 8;
  localparam int SBO_R_IOWR = 9;
  // Bus states each transaction occupies
  localparam logic [2:0] SBO_LEN_HOSTDATA = 3'h4;
  localparam logic [2:0] SBO_LEN_MEMRET = 3'h4;
  localparam logic [2:0] SBO_LEN_PIORET = 3'h1;
  localparam logic [2:0] SBO_LEN_BERR = 3'h1;
  localparam logic [2:0] SBO_LEN_SYNC = 3'h1;
  localparam logic [2:0] SBO_LEN_PURGE = 3'h1;
  localparam logic [2:0] SBO_LEN_MEMRD = 3'h1;
  localparam logic [2:0] SBO_LEN_MEMWR = 3'h5;
  localparam logic [2:0] SBO_LEN_IORD = 3'h1;
  localparam logic [2:0] SBO_LEN_IOWR = 3'h2;
  // Command-reset pulse length in bus states
  localparam logic [1:0] SBO_CMD_RESET_STATES = 2'h1;
  // Minimum bus states between two I/O transaction starts
  localparam logic [1:0] SBO_IO_SPACING = 2'h2;
  // Transaction type codes driven on the bus
  localparam logic [7:0] SBO_T_NONE = 8'h00;
  localparam logic [7:0] SBO_T_HOSTCTL = 8'h01;
  localparam logic [7:0] SBO_T_SHARRTN = 8'h02;
  localparam logic [7:0] SBO_T_PIORTN = 8'h03;
  localparam logic [7:0] SBO_T_BERR = 8'h48;
  localparam logic [7:0] SBO_T_SYNC = 8'h18;
  localparam logic [7:0] SBO_T_PURGE = 8'h1c;
  localparam logic [7:0] SBO_T_RDCUR = 8'hf0;
  localparam logic [7:0] SBO_T_RDSOP = 8'hf4;
  localparam logic [7:0] SBO_T_RDPRIV = 8'hf8;
  localparam logic [7:0] SBO_T_WRBACK = 8'h98;
  localparam logic [7:0] SBO_T_RDSHORT = 8'hc1;
  localparam logic [7:0] SBO_T_WRSHORT = 8'h81;
  // Memory read flavours chosen by the requester
  localparam logic [1:0] SBO_RD_SHAR_OR_PRIV = 2'h0;
  localparam logic [1:0] SBO_RD_CURRENT = 2'h1;
  localparam logic [1:0] SBO_RD_PRIV = 2'h2;
  typedef enum logic [1:0] {SBO_IDLE, SBO_BUSY} sbo_state_e;
endpackage

// File: sbo_properties.sv
// Concurrent checks on the request/grant carrier
`timescale 1ns/1ps
module sbo_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] grant,
  input wire logic coh_memreturn_request,
  input wire logic coh_sync_request,
  input wire logic coh_purge_request,
  input wire logic iox_mem_read_request,
  input wire logic iox_mem_write_request,
  input wire logic iox_io_read_request,
  input wire logic iox_io_write_request,
  input wire logic iox_stop_io,
  input wire logic iox_cmd_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic io_go;
  // An I/O start is a granted I/O read or write request
  assign io_go = grant[8] && iox_io_read_request
    || grant[9] && iox_io_write_request;
  one_grant_a: assert property ($onehot0(grant))
    else $error("more than one grant");
  stop_io_a: assert property (iox_stop_io |-> grant[9:8] == 2'h0)
    else $error("I/O grant during stop");
  io_gap_a: assert property (io_go |=> grant[9:8] == 2'h0)
    else $error("I/O starts too close");
  iowr_len_a: assert property (
    grant[9] && iox_io_write_request |=> grant == 10'h0)
    else $error("grant inside I/O write");
  memret_len_a: assert property (
    grant[1] && coh_memreturn_request |=> (grant == 10'h0) [*3])
    else $error("grant inside memory return");
  memwr_len_a: assert property (
    grant[7] && iox_mem_write_request |=> (grant == 10'h0) [*4])
    else $error("grant inside memory write");
  sync_one_a: assert property (
    grant[4] && coh_sync_request && coh_purge_request |=> grant != 10'h0)
    else $error("sync held the bus too long");
  purge_one_a: assert property (
    grant[5] && coh_purge_request && iox_mem_read_request
    |=> grant != 10'h0)
    else $error("purge held the bus too long");
  cmd_pulse_a: assert property ($rose(iox_cmd_reset) |=> !iox_cmd_reset)
    else $error("command reset too long");
endmodule

// File: sbo_requester.sv
// Requester end: holds requests until granted and drained
`timescale 1ns/1ps
module sbo_requester
  import sbo_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  sbo_if.requester bus,
  input wire logic [9:0] post,
  input wire logic shared_in,
  input wire logic [1:0] read_kind_in,
  input wire logic zerolen_hint_in,
  input wire logic zerolen_in,
  input wire logic [3:0] zerolen_id_in,
  input wire logic stop_io_in,
  input wire logic broadcast_reset_seen,
  output logic [9:0] started
);
  // Pending counts per requester; a pulse on post adds one
  logic [3:0] pend_q [SBO_NREQ];
  logic rst_pulse_q;
  logic bcast_q;

  // Held high while any remain pending; grant retires one
  genvar g;
  for (g = 0; g < SBO_NREQ; g++) begin : g_pend
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        pend_q[g] <= 4'h0;
      end else if (post[g] && !bus.grant[g]) begin
        pend_q[g] <= pend_q[g] + 4'h1;
      end else if (!post[g] && bus.grant[g] && pend_q[g] != 4'h0) begin
        pend_q[g] <= pend_q[g] - 4'h1;
      end
    end
  end

  // Request lines are levels from the pending counts
  always_comb begin
    bus.iox_hostdata_return_request = pend_q[SBO_R_HOSTDATA] != 4'h0;
    bus.coh_memreturn_request = pend_q[SBO_R_MEMRET] != 4'h0;
    bus.iox_pio_return_request = pend_q[SBO_R_PIORET] != 4'h0;
    bus.bin_broad_error_request = pend_q[SBO_R_BERR] != 4'h0;
    bus.coh_sync_request = pend_q[SBO_R_SYNC] != 4'h0;
    bus.coh_purge_request = pend_q[SBO_R_PURGE] != 4'h0;
    bus.iox_mem_read_request = pend_q[SBO_R_MEMRD] != 4'h0;
    bus.iox_mem_write_request = pend_q[SBO_R_MEMWR] != 4'h0;
    bus.iox_io_read_request = pend_q[SBO_R_IORD] != 4'h0;
    bus.iox_io_write_request = pend_q[SBO_R_IOWR] != 4'h0;
    // Qualifiers ride along with their request line
    bus.coh_shared = shared_in && bus.coh_memreturn_request;
    bus.iox_mem_read_kind = read_kind_in;
    bus.iox_zerolen_hint = zerolen_hint_in && bus.iox_mem_read_request;
    bus.coh_zerolen_return_strobe = zerolen_in;
    bus.coh_zerolen_trans_id = zerolen_id_in;
    bus.iox_stop_io = stop_io_in;
    bus.iox_cmd_reset = rst_pulse_q;
  end

  // Command reset is a single-state pulse on each new broadcast; one
  // held for several states still gives only one pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bcast_q <= 1'b0;
      rst_pulse_q <= 1'b0;
    end else begin
      bcast_q <= broadcast_reset_seen;
      rst_pulse_q <= broadcast_reset_seen && !bcast_q;
    end
  end

  // Reports which transaction started this state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      started <= 10'h000;
    end else begin
      started <= bus.grant & {bus.iox_io_write_request,
        bus.iox_io_read_request, bus.iox_mem_write_request,
        bus.iox_mem_read_request, bus.coh_purge_request,
        bus.coh_sync_request, bus.bin_broad_error_request,
        bus.iox_pio_return_request, bus.coh_memreturn_request,
        bus.iox_hostdata_return_request};
    end
  end
endmodule

// File: test_system_bus_output_request_grant.sv
// Self-checking bench joining the requester and master ends
`timescale 1ns/1ps
module test_system_bus_output_request_grant;
  import sbo_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] post = 10'h0;
  logic shared_in = 1'b0;
  logic [1:0] read_kind_in = 2'h0;
  logic zerolen_hint_in = 1'b0;
  logic zerolen_in = 1'b0;
  logic [3:0] zerolen_id_in = 4'h0;
  logic stop_io_in = 1'b0;
  logic bcast = 1'b0;
  logic [7:0] bus_ttype;
  logic [9:0] started;
  logic bus_valid, bus_zerolen_hint, zerolen_return, cmd_reset_seen;
  logic [3:0] zerolen_trans_id;
  logic [7:0] kind_t [3] = '{SBO_T_RDSOP, SBO_T_RDCUR, SBO_T_RDPRIV};
  logic [8:0] exp_q [$];
  logic [3:0] id_q [$];
  logic [9:0] who_q [$];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int pulses = 0;
  int seed = 32'hd42e;
  sbo_if bus ();
  sbo_requester i_sbo_requester (.clock, .rst_n, .bus, .post, .shared_in,
    .read_kind_in, .zerolen_hint_in, .zerolen_in, .zerolen_id_in,
    .stop_io_in, .broadcast_reset_seen(bcast), .started);
  sbo_master i_sbo_master (.clock, .rst_n, .bus, .bus_ttype, .bus_valid,
    .bus_zerolen_hint, .zerolen_trans_id, .zerolen_return, .cmd_reset_seen);
  sbo_checker i_sbo_checker (.clock, .rst_n, .grant(bus.grant),
    .coh_memreturn_request(bus.coh_memreturn_request),
    .coh_sync_request(bus.coh_sync_request),
    .coh_purge_request(bus.coh_purge_request),
    .iox_mem_read_request(bus.iox_mem_read_request),
    .iox_mem_write_request(bus.iox_mem_write_request),
    .iox_io_read_request(bus.iox_io_read_request),
    .iox_io_write_request(bus.iox_io_write_request),
    .iox_stop_io(bus.iox_stop_io), .iox_cmd_reset(bus.iox_cmd_reset));
  always #5 clock = ~clock;
  // One compare task for each kind of result
  task automatic chk_type(input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value bus_ttype expected %h seen %h", exp, got);
    end
  endtask
  task automatic chk_started(input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value started expected %h seen %h", exp, got);
    end
  endtask
  task automatic chk_id(input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value zerolen_trans_id expected %h seen %h", exp, got);
    end
  endtask
  // Counts are kept by the bench itself and are never unknown
  task automatic chk_count(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Type and hint a start of line i should show, from the qualifiers
  function automatic logic [8:0] expect_of(input int i);
    logic [7:0] t;
    case (i)
      0, 1: t = shared_in && i == 1 ? SBO_T_SHARRTN : SBO_T_HOSTCTL;
      2: t = SBO_T_PIORTN;
      3: t = SBO_T_BERR;
      4: t = SBO_T_SYNC;
      5: t = SBO_T_PURGE;
      6: t = kind_t[read_kind_in];
      7: t = SBO_T_WRBACK;
      8: t = SBO_T_RDSHORT;
      default: t = SBO_T_WRSHORT;
    endcase
    return {i == 6 && zerolen_hint_in, t};
  endfunction
  // Notes go in priority order, the order the master grants them
  task automatic post_set(input logic [9:0] v);
    @(negedge clock);
    post = v;
    for (int i = 0; i < 10; i++) begin
      if (v[i]) begin
        exp_q.push_back(expect_of(i));
        who_q.push_back(10'h1 << i);
      end
    end
    @(negedge clock);
    post = 10'h0;
  endtask
  task automatic drain();
    for (int n = 0; n < 100 && exp_q.size() > 0; n++) @(negedge clock);
    chk_count("pending", 0, exp_q.size());
    exp_q.delete();
    who_q.delete();
  endtask
  // Each result is matched to the oldest note; an unexpected one fails
  // Outputs are looked at on the falling edge, well after they settle
  always @(negedge clock) begin
    if (rst_n && bus_valid !== 1'b0) begin
      if (exp_q.size() == 0) begin
        chk_type(9'h1ff, {bus_zerolen_hint, bus_ttype});
      end else begin
        chk_type(exp_q.pop_front(), {bus_zerolen_hint, bus_ttype});
        chk_started(who_q.pop_front(), started);
      end
    end
    if (rst_n && zerolen_return !== 1'b0) begin
      if (id_q.size() == 0) begin
        chk_count("zerolen extra", 0, 1);
      end else begin
        chk_id(id_q.pop_front(), zerolen_trans_id);
      end
    end
    if (cmd_reset_seen !== 1'b0) pulses++;
    cycles++;
    // Whole run needs about 130 cycles; a hang ends here
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    // Every request line on its own
    for (int i = 0; i < 10; i++) begin
      post_set(10'h1 << i);
      drain();
    end
    // Each read kind, plain and shared returns, hint on the private read
    for (int k = 0; k < 3; k++) begin
      read_kind_in = 2'(k);
      shared_in = k[0];
      zerolen_hint_in = (k == 2);
      post_set(10'h042);
      drain();
    end
    zerolen_hint_in = 1'b0;
    read_kind_in = 2'($unsigned($random(seed)) % 3);
    shared_in = 1'($random(seed));
    // All lines at once, then I/O pairs that must be spaced out
    post_set(10'h3ff);
    drain();
    post_set(10'h200);
    post_set(10'h300);
    drain();
    // Stop-I/O holds back both I/O kinds until released
    stop_io_in = 1'b1;
    post_set(10'h300);
    repeat (10) @(negedge clock);
    chk_count("held", 2, exp_q.size());
    stop_io_in = 1'b0;
    drain();
    // Back-to-back zero-length strobes need no grant
    repeat (4) begin
      @(negedge clock);
      zerolen_in = 1'b1;
      zerolen_id_in = 4'($random(seed));
      id_q.push_back(zerolen_id_in);
    end
    @(negedge clock);
    zerolen_in = 1'b0;
    // Broadcast held for several states, yet only one pulse may follow
    bcast = 1'b1;
    repeat (3) @(negedge clock);
    bcast = 1'b0;
    repeat (6) @(negedge clock);
    chk_count("cmd_reset pulses", 1, pulses);
    chk_count("ids left", 0, id_q.size());
    test_done();
  end
endmodule
